// >>> logic/irq_ctrl_pkg.sv
// Shared constants for the interrupt controller
package irq_ctrl_pkg;

    // ========================================================
    // Register indices in special data memory space
    localparam logic [1:0] ADDR_EDGE = 2'h0;
    localparam logic [1:0] ADDR_PRIA = 2'h1;
    localparam logic [1:0] ADDR_PRIB = 2'h2;
    localparam logic [1:0] ADDR_MFC  = 2'h3;

    // ========================================================
    // Primary control A bit positions
    localparam int GIE_BIT  = 0;
    localparam int EXTE_BIT = 1;
    localparam int TBAE_BIT = 2;
    localparam int TBBE_BIT = 3;
    localparam int EXTF_BIT = 4;
    localparam int TBAF_BIT = 5;
    localparam int TBBF_BIT = 6;

    // Primary control B bit positions
    localparam int GRPE_BIT = 0;
    localparam int EEPE_BIT = 1;
    localparam int ADCE_BIT = 2;
    localparam int GRPF_BIT = 4;
    localparam int EEPF_BIT = 5;
    localparam int ADCF_BIT = 6;

    // Multi-function control bit positions
    localparam int CMPE_BIT = 0;
    localparam int CMAE_BIT = 1;
    localparam int CMPF_BIT = 4;
    localparam int CMAF_BIT = 5;

    // ========================================================
    // Writable masks, reset value, edge field encodings
    localparam logic [7:0] EDGE_MASK = 8'h03;
    localparam logic [7:0] PRIA_MASK = 8'h7F;
    localparam logic [7:0] PRIB_MASK = 8'h77;
    localparam logic [7:0] MFC_MASK  = 8'h33;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Vector indices, in priority order
    localparam int VEC_EXT = 0;
    localparam int VEC_TBA = 1;
    localparam int VEC_TBB = 2;
    localparam int VEC_GRP = 3;
    localparam int VEC_EEP = 4;
    localparam int VEC_ADC = 5;
    localparam int NUM_VEC = 6;

endpackage : irq_ctrl_pkg

// >>> logic/mcu_interrupt_controller.sv
// Interrupt controller: flags, enables, edge select and vectoring
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - External pin edge raises external request flag
// - Accept timer, time base, EEPROM, converter requests
// - Vector request suspends program for servicing
// - Every source has flag and enable bit
// - Enables end in enable, flags in flag
// - Two primary registers plus multi-function register
// - Comparator matches feed one shared group request
// - Edge field: off, rising, falling, both
// - Unimplemented bits read as zero
// - Time base B flag at primary A bit 6
// - Time base A flag at primary A bit 5
// - Time base A enable at primary A bit 2
// - External pin enable at primary A bit 1
// - Registers live in special data memory
// - Flags set regardless; vector needs both enables
// - Service entry clears global enable
// - Flags still latch while servicing blocked

module mcu_interrupt_controller
    import irq_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    // Special data memory access
    input  wire logic [1:0]         reg_addr,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [7:0]         reg_wdata,
    output var  logic [7:0]         reg_rdata,
    // Event sources, one-cycle pulses except the pin
    input  wire logic               ext_pin,
    input  wire logic               timebase_a_evt,
    input  wire logic               timebase_b_evt,
    input  wire logic               eeprom_evt,
    input  wire logic               converter_evt,
    input  wire logic               cmp_a_match_evt,
    input  wire logic               cmp_p_match_evt,
    // CPU core
    input  wire logic               irq_ack,
    output var  logic               irq_req,
    output var  logic [2:0]         irq_vector
);

    // ========================================================
    // Register storage
    logic [7:0] external_edge_select;
    logic [7:0] primary_irq_control_a;
    logic [7:0] primary_irq_control_b;
    logic [7:0] multi_function_irq_control;

    logic       pin_meta;
    logic       pin_sync;
    logic       pin_prev;

    // ========================================================
    // Decode
    wire logic wr_edge = reg_wr && (reg_addr == ADDR_EDGE);
    wire logic wr_pria = reg_wr && (reg_addr == ADDR_PRIA);
    wire logic wr_prib = reg_wr && (reg_addr == ADDR_PRIB);
    wire logic wr_mfc  = reg_wr && (reg_addr == ADDR_MFC);

    wire logic [1:0] ext_edge_select_field = external_edge_select[1:0];
    wire logic rise_seen = pin_sync && !pin_prev;
    wire logic fall_seen = !pin_sync && pin_prev;
    wire logic ext_evt =
        ((ext_edge_select_field == EDGE_RISE) && rise_seen) ||
        ((ext_edge_select_field == EDGE_FALL) && fall_seen) ||
        ((ext_edge_select_field == EDGE_BOTH)
            && (rise_seen || fall_seen));

    wire logic global_irq_enable     = primary_irq_control_a[GIE_BIT];
    wire logic ext_pin_irq_enable    = primary_irq_control_a[EXTE_BIT];
    wire logic timebase_a_irq_enable = primary_irq_control_a[TBAE_BIT];
    wire logic timebase_b_irq_enable = primary_irq_control_a[TBBE_BIT];
    wire logic ext_pin_irq_flag      = primary_irq_control_a[EXTF_BIT];
    wire logic timebase_a_irq_flag   = primary_irq_control_a[TBAF_BIT];
    wire logic timebase_b_irq_flag   = primary_irq_control_a[TBBF_BIT];
    wire logic shared_group_irq_enable = primary_irq_control_b[GRPE_BIT];
    wire logic eeprom_irq_enable     = primary_irq_control_b[EEPE_BIT];
    wire logic converter_irq_enable  = primary_irq_control_b[ADCE_BIT];
    wire logic shared_group_irq_flag = primary_irq_control_b[GRPF_BIT];
    wire logic eeprom_irq_flag       = primary_irq_control_b[EEPF_BIT];
    wire logic converter_irq_flag    = primary_irq_control_b[ADCF_BIT];
    wire logic cmp_p_match_irq_enable =
        multi_function_irq_control[CMPE_BIT];
    wire logic cmp_a_match_irq_enable =
        multi_function_irq_control[CMAE_BIT];
    wire logic cmp_p_match_irq_flag = multi_function_irq_control[CMPF_BIT];
    wire logic cmp_a_match_irq_flag = multi_function_irq_control[CMAF_BIT];

    // Group request is level-like: set while any enabled member pends
    wire logic group_evt =
        (cmp_a_match_irq_flag && cmp_a_match_irq_enable) ||
        (cmp_p_match_irq_flag && cmp_p_match_irq_enable);

    // ========================================================
    // Pending-and-enabled sources, lowest index wins
    wire logic [NUM_VEC-1:0] active = {
        converter_irq_flag    && converter_irq_enable,
        eeprom_irq_flag       && eeprom_irq_enable,
        shared_group_irq_flag && shared_group_irq_enable,
        timebase_b_irq_flag   && timebase_b_irq_enable,
        timebase_a_irq_flag   && timebase_a_irq_enable,
        ext_pin_irq_flag      && ext_pin_irq_enable
    };

    logic [2:0] next_vector;
    always_comb begin
        next_vector = 3'h0;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (active[i]) begin
                next_vector = 3'(i);
            end
        end
    end

    wire logic next_req = global_irq_enable && (|active)
        && !irq_ack;

    // Acknowledged source is cleared in hardware, except the shared
    // group whose members are cleared by software
    wire logic [NUM_VEC-1:0] ack_clr;
    genvar g;
    generate
        for (g = 0; g < NUM_VEC; g++) begin : g_ack
            assign ack_clr[g] = irq_ack && irq_req
                && (irq_vector == 3'(g)) && (g != VEC_GRP);
        end
    endgenerate

    // ========================================================
    // Next register values; an event wins over any clear
    logic [7:0] next_pria;
    logic [7:0] next_prib;
    logic [7:0] next_mfc;

    always_comb begin
        next_pria = wr_pria ? (reg_wdata & PRIA_MASK)
                            : primary_irq_control_a;
        if (irq_ack) begin
            next_pria[GIE_BIT] = 1'b0;
        end
        if (ack_clr[VEC_EXT]) next_pria[EXTF_BIT] = 1'b0;
        if (ack_clr[VEC_TBA]) next_pria[TBAF_BIT] = 1'b0;
        if (ack_clr[VEC_TBB]) next_pria[TBBF_BIT] = 1'b0;
        if (ext_evt)        next_pria[EXTF_BIT] = 1'b1;
        if (timebase_a_evt) next_pria[TBAF_BIT] = 1'b1;
        if (timebase_b_evt) next_pria[TBBF_BIT] = 1'b1;

        next_prib = wr_prib ? (reg_wdata & PRIB_MASK)
                            : primary_irq_control_b;
        if (ack_clr[VEC_EEP]) next_prib[EEPF_BIT] = 1'b0;
        if (ack_clr[VEC_ADC]) next_prib[ADCF_BIT] = 1'b0;
        if (eeprom_evt)    next_prib[EEPF_BIT] = 1'b1;
        if (converter_evt) next_prib[ADCF_BIT] = 1'b1;
        if (group_evt)     next_prib[GRPF_BIT] = 1'b1;

        next_mfc = wr_mfc ? (reg_wdata & MFC_MASK)
                          : multi_function_irq_control;
        if (cmp_a_match_evt) next_mfc[CMAF_BIT] = 1'b1;
        if (cmp_p_match_evt) next_mfc[CMPF_BIT] = 1'b1;
    end

    // Unmasked bits are never stored, so they read back as zero
    wire logic [7:0] next_rdata =
        (reg_addr == ADDR_EDGE) ? external_edge_select :
        (reg_addr == ADDR_PRIA) ? primary_irq_control_a :
        (reg_addr == ADDR_PRIB) ? primary_irq_control_b :
                                  multi_function_irq_control;

    // ========================================================
    // Pin synchroniser and edge history
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= ext_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // ========================================================
    // Registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            external_edge_select       <= REG_RESET;
            primary_irq_control_a      <= REG_RESET;
            primary_irq_control_b      <= REG_RESET;
            multi_function_irq_control <= REG_RESET;
        end else begin
            if (wr_edge) begin
                external_edge_select <= reg_wdata & EDGE_MASK;
            end
            primary_irq_control_a      <= next_pria;
            primary_irq_control_b      <= next_prib;
            multi_function_irq_control <= next_mfc;
        end
    end

    // ========================================================
    // Outputs
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            reg_rdata  <= REG_RESET;
            irq_req    <= 1'b0;
            irq_vector <= 3'h0;
        end else begin
            reg_rdata  <= reg_rd ? next_rdata : REG_RESET;
            irq_req    <= next_req;
            irq_vector <= next_vector;
        end
    end

endmodule : mcu_interrupt_controller

`default_nettype wire

// >>> test/irq_ctrl_assertions.sv
// Port-level checks for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker
    import irq_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // Register access
    input wire logic [1:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // CPU side
    input wire logic       irq_ack,
    input wire logic       irq_req,
    input wire logic [2:0] irq_vector
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ========================================
    // Register reads
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    property p_edge_rsv;
        reg_rd && reg_addr == ADDR_EDGE |=> reg_rdata[7:2] == 6'h00;
    endproperty
    a_edge_rsv: assert property (p_edge_rsv)
        else $error("edge reserved bits set");
    property p_pria_rsv;
        reg_rd && reg_addr == ADDR_PRIA |=> !reg_rdata[7];
    endproperty
    a_pria_rsv: assert property (p_pria_rsv)
        else $error("primary A bit 7 set");
    property p_prib_rsv;
        reg_rd && reg_addr == ADDR_PRIB |=> (reg_rdata & ~PRIB_MASK) == 8'h00;
    endproperty
    a_prib_rsv: assert property (p_prib_rsv)
        else $error("primary B reserved bits set");
    property p_mfc_rsv;
        reg_rd && reg_addr == ADDR_MFC |=> (reg_rdata & ~MFC_MASK) == 8'h00;
    endproperty
    a_mfc_rsv: assert property (p_mfc_rsv)
        else $error("group register reserved bits set");
    // Edge field has no hardware-set bits, so a read returns the write
    property p_edge_rw;
        reg_wr && reg_addr == ADDR_EDGE ##2 reg_rd && reg_addr == ADDR_EDGE
        && !reg_wr |=> reg_rdata == ($past(reg_wdata, 3) & EDGE_MASK);
    endproperty
    a_edge_rw: assert property (p_edge_rw)
        else $error("edge field readback wrong");
    // ========================================
    // Vectoring
    property p_ack_drop; irq_req && irq_ack |=> !irq_req; endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("request stayed after ack");
    property p_gie_off;
        reg_wr && reg_addr == ADDR_PRIA && !reg_wdata[GIE_BIT]
        |=> ##1 !irq_req;
    endproperty
    a_gie_off: assert property (p_gie_off)
        else $error("request without global enable");
    property p_req_hold;
        irq_req && !irq_ack && !reg_wr && !$past(reg_wr) && !$past(irq_ack)
        |=> irq_req;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped while unserved");
    c_ack: cover property (irq_req && irq_ack);
    c_adc: cover property (irq_req && irq_vector == 3'h5);
    c_edge: cover property (reg_rd && reg_addr == ADDR_EDGE);
endmodule : irq_ctrl_checker
bind mcu_interrupt_controller irq_ctrl_checker irq_ctrl_checker_i (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector));
`default_nettype wire

// >>> test/cpu_core_model.sv
// Behavioural CPU core taking vectored requests after a set delay
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Controller side
    input  wire logic       irq_req,
    input  wire logic [2:0] irq_vector,
    input  wire logic [3:0] ack_wait,
    output var  logic       irq_ack,
    // Record of taken vectors
    output var  logic [2:0] taken_vec,
    output var  logic [3:0] takes
);
    logic [3:0] waited;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            irq_ack <= 1'b0;
            waited <= 4'h0;
            takes <= 4'h0;
            taken_vec <= 3'h0;
        end else if (irq_req && !irq_ack && waited >= ack_wait) begin
            irq_ack <= 1'b1;
            taken_vec <= irq_vector;
            takes <= takes + 4'h1;
            waited <= 4'h0;
        end else begin
            irq_ack <= 1'b0;
            waited <= (irq_req && !irq_ack) ? waited + 4'h1 : 4'h0;
        end
    end
endmodule : cpu_core_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import irq_ctrl_pkg::*;
    logic       sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic       ext_pin = 1'b0, irq_ack, irq_req;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [5:0] evt = 6'h00;
    logic [3:0] ack_wait = 4'h3, takes;
    logic [2:0] irq_vector, taken_vec;
    int         fails = 0, checked = 0, cycles = 0;
    always #25 sys_clk = ~sys_clk;
    mcu_interrupt_controller mcu_interrupt_controller_i (.sys_clk(sys_clk),
        .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
        .timebase_a_evt(evt[0]), .timebase_b_evt(evt[1]),
        .eeprom_evt(evt[2]), .converter_evt(evt[3]),
        .cmp_a_match_evt(evt[4]), .cmp_p_match_evt(evt[5]),
        .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector));
    cpu_core_model cpu_core_model_i (.sys_clk(sys_clk), .nrst(nrst),
        .irq_req(irq_req), .irq_vector(irq_vector), .ack_wait(ack_wait),
        .irq_ack(irq_ack), .taken_vec(taken_vec), .takes(takes));
    // ========================================
    // Access tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
    endtask : rd
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_sim();
        end
    end
    // ========================================
    // Tests
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) rd(2'(i), REG_RESET);
        $display("reset values done");
        wr(ADDR_EDGE, 8'hFF);
        rd(ADDR_EDGE, 8'h03);
        wr(ADDR_MFC, 8'hFF);
        rd(ADDR_MFC, 8'h33);
        wr(ADDR_PRIB, 8'hFF);
        rd(ADDR_PRIB, 8'h77);
        wr(ADDR_PRIA, 8'h7E);
        rd(ADDR_PRIA, 8'h7E);
        wr(ADDR_PRIA, 8'h00);
        wr(ADDR_MFC, 8'h00);
        wr(ADDR_PRIB, 8'h00);
        rd(ADDR_PRIB, 8'h00);
        $display("register map done");
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_EDGE, 8'(m));
            @(posedge sys_clk) ext_pin <= 1'b1;
            repeat (6) @(posedge sys_clk);
            rd(ADDR_PRIA, m[0] ? 8'h10 : 8'h00);
            wr(ADDR_PRIA, 8'h00);
            @(posedge sys_clk) ext_pin <= 1'b0;
            repeat (6) @(posedge sys_clk);
            rd(ADDR_PRIA, m[1] ? 8'h10 : 8'h00);
            wr(ADDR_PRIA, 8'h00);
        end
        $display("edge modes done");
        wr(ADDR_PRIB, 8'h00);
        wr(ADDR_MFC, 8'h02);
        @(posedge sys_clk) evt <= 6'h1A;
        @(posedge sys_clk) evt <= 6'h00;
        rd(ADDR_MFC, 8'h22);
        rd(ADDR_PRIA, 8'h40);
        rd(ADDR_PRIB, 8'h50);
        wr(ADDR_PRIB, 8'h54);
        wr(ADDR_PRIA, 8'h49);
        repeat (10) @(posedge sys_clk);
        chk({4'h0, takes}, 8'h01);
        chk({5'h0, taken_vec}, 8'(VEC_TBB));
        rd(ADDR_PRIA, 8'h08);
        ack_wait <= 4'h0;
        wr(ADDR_PRIA, 8'h09);
        repeat (10) @(posedge sys_clk);
        chk({4'h0, takes}, 8'h02);
        chk({5'h0, taken_vec}, 8'(VEC_ADC));
        rd(ADDR_PRIB, 8'h14);
        wr(ADDR_MFC, 8'h01);
        wr(ADDR_PRIB, 8'h00);
        @(posedge sys_clk) evt <= 6'h25;
        @(posedge sys_clk) evt <= 6'h00;
        rd(ADDR_PRIA, 8'h28);
        rd(ADDR_PRIB, 8'h30);
        rd(ADDR_MFC, 8'h11);
        $display("vectoring done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
